// >>> setcc_sysreg_exec.sv
// Execution control for set-on-condition and store-system-register instructions
`timescale 1ns/100ps

// Function
// RL1 - 0F 9C decodes as signed-less set
// RL2 - 0F 9E decodes as signed-less-or-equal set
// RL3 - 0F 93 decodes as not-below set
// RL4 - 0F 97 decodes as above set
// RL5 - 0F 95 decodes as not-equal set
// RL6 - 0F 9D decodes as greater-or-equal set
// RL7 - 0F 9F decodes as greater set
// RL8 - 0F 91 no-overflow, 0F 90 overflow set
// RL9 - 0F 9B parity odd, 0F 9A parity even
// RL10 - 0F 99 sign clear, 0F 98 sign set
// RL11 - Set needs reg 000, one clock, flags kept
// RL12 - 0F 01 /0 stores global table, six clocks
// RL13 - 0F 01 /1 stores interrupt table, six clocks
// RL14 - 0F 00 /0 local table, one clock protected
// RL15 - 0F 00 /1 task: four real, three protected
// RL16 - 0F 01 /4 status word, four clocks
// RL17 - Set writes one if condition holds, else zero
// RL18 - Less is sign xor overflow; below uses carry
module setcc_sysreg_exec (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        instValid,
	output logic             instReady,
	input  wire logic [7:0]  opByte0,
	input  wire logic [7:0]  opByte1,
	input  wire logic [7:0]  modRm,
	input  wire logic        protMode,
	input  wire logic        flagCarry,
	input  wire logic        flagZero,
	input  wire logic        flagSign,
	input  wire logic        flagOverflow,
	input  wire logic        flagParity,
	input  wire logic [31:0] gdtBase,
	input  wire logic [15:0] gdtLimit,
	input  wire logic [31:0] idtBase,
	input  wire logic [15:0] idtLimit,
	input  wire logic [15:0] ldtSelector,
	input  wire logic [15:0] taskSelector,
	input  wire logic [15:0] statusWord,
	output logic             retire,
	output logic             regWrite,
	output logic             memWrite,
	output logic             badOpcode,
	output logic [2:0]       destReg,
	output logic [2:0]       wrBytes,
	output logic [47:0]      wrData
);
	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rstSync1_q;
	logic rstSync2_q;
	logic rstN;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rstSync1_q <= 1'b0;
			rstSync2_q <= 1'b0;
		end else begin
			rstSync1_q <= 1'b1;
			rstSync2_q <= rstSync1_q;
		end
	end
	assign rstN = rstSync2_q;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	decode_if dec ();

	op_classifier uClassifier (
		.bus (dec)
	);

	setcc_condition uCondition (
		.bus (dec)
	);

	assign dec.opByte0      = opByte0;
	assign dec.opByte1      = opByte1;
	assign dec.modRm        = modRm;
	assign dec.protMode     = protMode;
	assign dec.flagCarry    = flagCarry;
	assign dec.flagZero     = flagZero;
	assign dec.flagSign     = flagSign;
	assign dec.flagOverflow = flagOverflow;
	assign dec.flagParity   = flagParity;

	// ----------------------------------------------------------------
	// Execution sequencing
	// ----------------------------------------------------------------
	logic        accept;
	logic        toReg;
	logic [2:0]  remaining_q, remaining_d;
	logic        instReady_q, instReady_d;
	logic        retire_q, retire_d;
	logic        regWrite_q, regWrite_d;
	logic        memWrite_q, memWrite_d;
	logic        fault_q, fault_d;
	logic        pendReg_q, pendReg_d;
	logic        pendMem_q, pendMem_d;
	logic        pendFault_q, pendFault_d;
	logic [2:0]  destReg_q, destReg_d;
	logic [2:0]  wrBytes_q, wrBytes_d;
	logic [47:0] wrData_q, wrData_d;

	assign accept = instValid && instReady_q;
	assign toReg  = (modRm[7:6] == setcc_sysreg_pkg::MOD_REGISTER);

	always_comb begin
		remaining_d = remaining_q;
		instReady_d = instReady_q;
		retire_d    = 1'b0;
		regWrite_d  = 1'b0;
		memWrite_d  = 1'b0;
		fault_d     = 1'b0;
		pendReg_d   = pendReg_q;
		pendMem_d   = pendMem_q;
		pendFault_d = pendFault_q;
		destReg_d   = destReg_q;
		wrBytes_d   = wrBytes_q;
		wrData_d    = wrData_q;
		if (accept) begin
			// Flags are only read; no path here writes them
			destReg_d   = modRm[2:0];
			wrData_d    = 48'h0;
			wrBytes_d   = setcc_sysreg_pkg::BYTES_WORD;
			pendFault_d = dec.illegal; // see RL14
			pendReg_d   = toReg && !dec.illegal;
			pendMem_d   = !toReg && !dec.illegal;
			unique case (dec.opKind)
				setcc_sysreg_pkg::SET_ON_CONDITION: begin
					wrBytes_d = setcc_sysreg_pkg::BYTES_SETCC;
					if (!dec.illegal) begin
						wrData_d = {47'h0, dec.condTrue}; // see RL17
					end
				end
				setcc_sysreg_pkg::STORE_GLOBAL_TABLE_REG: begin
					wrBytes_d = setcc_sysreg_pkg::BYTES_TABLE;
					wrData_d  = {gdtBase, gdtLimit}; // see RL12
				end
				setcc_sysreg_pkg::STORE_INTERRUPT_TABLE_REG: begin
					wrBytes_d = setcc_sysreg_pkg::BYTES_TABLE;
					wrData_d  = {idtBase, idtLimit}; // see RL13
				end
				setcc_sysreg_pkg::STORE_LOCAL_TABLE_REG: begin
					if (!dec.illegal) begin
						wrData_d = {32'h0, ldtSelector};
					end
				end
				setcc_sysreg_pkg::STORE_TASK_REG: begin
					wrData_d = {32'h0, taskSelector}; // see RL15
				end
				setcc_sysreg_pkg::STORE_MACHINE_STATUS_WORD: begin
					wrData_d = {32'h0, statusWord}; // see RL16
				end
				setcc_sysreg_pkg::OP_NONE: begin
					wrBytes_d = setcc_sysreg_pkg::BYTES_SETCC;
				end
				default: begin
					wrBytes_d = setcc_sysreg_pkg::BYTES_SETCC;
				end
			endcase
			if (dec.cycles == setcc_sysreg_pkg::CYC_SETCC) begin
				// Single-clock forms retire at once and keep the port open
				retire_d    = 1'b1; // see RL11
				regWrite_d  = toReg && !dec.illegal;
				memWrite_d  = !toReg && !dec.illegal;
				fault_d     = dec.illegal;
				remaining_d = setcc_sysreg_pkg::RST_REMAINING;
				instReady_d = 1'b1;
			end else begin
				remaining_d = dec.cycles - 3'h1;
				instReady_d = 1'b0;
			end
		end else if (remaining_q != 3'h0) begin
			remaining_d = remaining_q - 3'h1;
			if (remaining_q == 3'h1) begin
				retire_d    = 1'b1;
				regWrite_d  = pendReg_q;
				memWrite_d  = pendMem_q;
				fault_d     = pendFault_q;
				instReady_d = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			remaining_q <= setcc_sysreg_pkg::RST_REMAINING;
			instReady_q <= setcc_sysreg_pkg::RST_READY;
			retire_q    <= 1'b0;
			regWrite_q  <= 1'b0;
			memWrite_q  <= 1'b0;
			fault_q     <= 1'b0;
			pendReg_q   <= 1'b0;
			pendMem_q   <= 1'b0;
			pendFault_q <= 1'b0;
			destReg_q   <= 3'h0;
			wrBytes_q   <= 3'h0;
			wrData_q    <= 48'h0;
		end else begin
			remaining_q <= remaining_d;
			instReady_q <= instReady_d;
			retire_q    <= retire_d;
			regWrite_q  <= regWrite_d;
			memWrite_q  <= memWrite_d;
			fault_q     <= fault_d;
			pendReg_q   <= pendReg_d;
			pendMem_q   <= pendMem_d;
			pendFault_q <= pendFault_d;
			destReg_q   <= destReg_d;
			wrBytes_q   <= wrBytes_d;
			wrData_q    <= wrData_d;
		end
	end

	assign instReady = instReady_q;
	assign retire    = retire_q;
	assign regWrite  = regWrite_q;
	assign memWrite  = memWrite_q;
	assign badOpcode = fault_q;
	assign destReg   = destReg_q;
	assign wrBytes   = wrBytes_q;
	assign wrData    = wrData_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstN);

	logic isEsc;
	assign isEsc = accept && (opByte0 == setcc_sysreg_pkg::OPC_ESCAPE);

	property p_setcc(opc, expected);
		isEsc && opByte1 == opc && modRm[5:3] == setcc_sysreg_pkg::REG_SETCC
		|=> retire_q && !fault_q && wrData_q == {47'h0, expected};
	endproperty

	a_signed_less_value: assert property ( // see RL1
		p_setcc(setcc_sysreg_pkg::OPC_SET_IF_SIGNED_LESS, $past(flagSign) != $past(flagOverflow)))
		else $error("signed less result wrong");
	a_less_equal_value: assert property ( // see RL2
		p_setcc(setcc_sysreg_pkg::OPC_SET_IF_SIGNED_LESS_EQUAL,
		($past(flagSign) != $past(flagOverflow)) || $past(flagZero)))
		else $error("less or equal result wrong");
	a_not_below_value: assert property (p_setcc(setcc_sysreg_pkg::OPC_SET_IF_NOT_BELOW, // see RL3
		!$past(flagCarry))) else $error("not below result wrong");
	a_above_value: assert property (p_setcc(setcc_sysreg_pkg::OPC_SET_IF_ABOVE, // see RL4
		!($past(flagCarry) || $past(flagZero)))) else $error("above result wrong");
	a_not_equal_value: assert property (p_setcc(setcc_sysreg_pkg::OPC_SET_IF_NOT_EQUAL, // see RL5
		!$past(flagZero))) else $error("not equal result wrong");
	a_greater_equal_value: assert property ( // see RL6
		p_setcc(setcc_sysreg_pkg::OPC_SET_IF_GREATER_EQUAL, $past(flagSign) == $past(flagOverflow)))
		else $error("greater equal result wrong");
	a_greater_value: assert property (p_setcc(setcc_sysreg_pkg::OPC_SET_IF_GREATER, // see RL7
		($past(flagSign) == $past(flagOverflow)) && !$past(flagZero)))
		else $error("greater result wrong");
	a_overflow_pair: assert property (p_setcc(setcc_sysreg_pkg::OPC_SET_IF_NO_OVERFLOW, // see RL8
		!$past(flagOverflow))) else $error("no overflow result wrong");
	a_parity_pair: assert property (p_setcc(setcc_sysreg_pkg::OPC_SET_IF_PARITY_ODD, // see RL9
		!$past(flagParity))) else $error("parity odd result wrong");
	a_sign_pair: assert property (p_setcc(setcc_sysreg_pkg::OPC_SET_IF_SIGN_SET, // see RL10
		$past(flagSign))) else $error("sign set result wrong");
	a_below_equal_value: assert property ( // see RL18
		p_setcc(setcc_sysreg_pkg::OPC_SET_IF_BELOW_EQUAL, $past(flagCarry) || $past(flagZero)))
		else $error("below or equal result wrong");

	a_setcc_reg_field: assert property ( // see RL11
		isEsc && opByte1[7:4] == setcc_sysreg_pkg::OPC_SETCC_ROW && modRm[5:3] != 3'h0
		|=> retire_q && fault_q && !regWrite_q && !memWrite_q)
		else $error("set with nonzero reg field not refused");
	a_setcc_binary: assert property ( // see RL17
		retire_q && wrBytes_q == setcc_sysreg_pkg::BYTES_SETCC |-> wrData_q[47:1] == 47'h0)
		else $error("set result not zero or one");
	a_global_table_time: assert property ( // see RL12
		isEsc && opByte1 == setcc_sysreg_pkg::OPC_GROUP_TABLE_MSW && modRm[5:3] == 3'h0
		&& !toReg |=> !retire_q [*5] ##1 (retire_q && memWrite_q
		&& wrBytes_q == setcc_sysreg_pkg::BYTES_TABLE && wrData_q[15:0] == $past(gdtLimit, 6)))
		else $error("global table store timing or data wrong");
	a_interrupt_table_time: assert property ( // see RL13
		isEsc && opByte1 == setcc_sysreg_pkg::OPC_GROUP_TABLE_MSW && modRm[5:3] == 3'h1
		&& !toReg |=> !retire_q [*5] ##1 (retire_q && wrData_q[47:16] == $past(idtBase, 6)))
		else $error("interrupt table store timing or data wrong");
	a_local_table_mode: assert property ( // see RL14
		isEsc && opByte1 == setcc_sysreg_pkg::OPC_GROUP_LOCAL_TASK && modRm[5:3] == 3'h0
		|=> retire_q && (fault_q == !$past(protMode)))
		else $error("local table store mode handling wrong");
	a_task_reg_time: assert property ( // see RL15
		isEsc && opByte1 == setcc_sysreg_pkg::OPC_GROUP_LOCAL_TASK && modRm[5:3] == 3'h1
		&& protMode |=> !retire_q [*2] ##1 (retire_q && !fault_q))
		else $error("task register store timing wrong");
	a_status_word_time: assert property ( // see RL16
		isEsc && opByte1 == setcc_sysreg_pkg::OPC_GROUP_TABLE_MSW && modRm[5:3] == 3'h4
		|=> !instReady_q [*3] ##0 !retire_q ##1 (retire_q && wrData_q[15:0] == $past(statusWord, 4)))
		else $error("status word store timing or data wrong");

	c_setcc_register: cover property (isEsc && opByte1[7:4] == setcc_sysreg_pkg::OPC_SETCC_ROW
		&& toReg ##1 regWrite_q);
	c_back_to_back: cover property (retire_q && accept ##1 retire_q);
	c_table_memory: cover property (memWrite_q && wrBytes_q == setcc_sysreg_pkg::BYTES_TABLE);
	c_fault_seen: cover property (fault_q);

endmodule // setcc_sysreg_exec

// >>> setcc_sysreg_pkg.sv
// Constants and types for the set-on-condition and store-system-register slice
package setcc_sysreg_pkg;

	// ----------------------------------------------------------------
	// Opcode bytes and ModRM fields
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_ESCAPE                   = 8'h0F;
	localparam logic [7:0] OPC_GROUP_LOCAL_TASK         = 8'h00;
	localparam logic [7:0] OPC_GROUP_TABLE_MSW          = 8'h01;
	localparam logic [3:0] OPC_SETCC_ROW                = 4'h9;
	localparam logic [7:0] OPC_SET_IF_OVERFLOW_FLAG     = 8'h90;
	localparam logic [7:0] OPC_SET_IF_NO_OVERFLOW       = 8'h91;
	localparam logic [7:0] OPC_SET_IF_NOT_BELOW         = 8'h93;
	localparam logic [7:0] OPC_SET_IF_NOT_EQUAL         = 8'h95;
	localparam logic [7:0] OPC_SET_IF_BELOW_EQUAL       = 8'h96;
	localparam logic [7:0] OPC_SET_IF_ABOVE             = 8'h97;
	localparam logic [7:0] OPC_SET_IF_SIGN_SET          = 8'h98;
	localparam logic [7:0] OPC_SET_IF_SIGN_CLEAR        = 8'h99;
	localparam logic [7:0] OPC_SET_IF_PARITY_EVEN       = 8'h9A;
	localparam logic [7:0] OPC_SET_IF_PARITY_ODD        = 8'h9B;
	localparam logic [7:0] OPC_SET_IF_SIGNED_LESS       = 8'h9C;
	localparam logic [7:0] OPC_SET_IF_GREATER_EQUAL     = 8'h9D;
	localparam logic [7:0] OPC_SET_IF_SIGNED_LESS_EQUAL = 8'h9E;
	localparam logic [7:0] OPC_SET_IF_GREATER           = 8'h9F;
	localparam logic [2:0] REG_SETCC                    = 3'h0;
	localparam logic [2:0] REG_GLOBAL_TABLE             = 3'h0;
	localparam logic [2:0] REG_INTERRUPT_TABLE          = 3'h1;
	localparam logic [2:0] REG_STATUS_WORD              = 3'h4;
	localparam logic [2:0] REG_LOCAL_TABLE              = 3'h0;
	localparam logic [2:0] REG_TASK                     = 3'h1;
	localparam logic [1:0] MOD_REGISTER                 = 2'h3;

	// ----------------------------------------------------------------
	// Clock counts, result sizes and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] CYC_SETCC      = 3'h1;
	localparam logic [2:0] CYC_TABLE      = 3'h6;
	localparam logic [2:0] CYC_LOCAL_PROT = 3'h1;
	localparam logic [2:0] CYC_TASK_REAL  = 3'h4;
	localparam logic [2:0] CYC_TASK_PROT  = 3'h3;
	localparam logic [2:0] CYC_STATUS     = 3'h4;
	localparam logic [2:0] CYC_FAULT      = 3'h1;
	localparam logic [2:0] BYTES_SETCC    = 3'h1;
	localparam logic [2:0] BYTES_TABLE    = 3'h6;
	localparam logic [2:0] BYTES_WORD     = 3'h2;
	localparam logic [2:0] RST_REMAINING  = 3'h0;
	localparam logic       RST_READY      = 1'b1;

	typedef enum logic [2:0] {
		OP_NONE                   = 3'b000,
		SET_ON_CONDITION          = 3'b001,
		STORE_GLOBAL_TABLE_REG    = 3'b010,
		STORE_INTERRUPT_TABLE_REG = 3'b011,
		STORE_LOCAL_TABLE_REG     = 3'b100,
		STORE_TASK_REG            = 3'b101,
		STORE_MACHINE_STATUS_WORD = 3'b110
	} op_kind_t;

endpackage

// >>> decode_if.sv
// Carrier between the execution control and its decode helpers
`timescale 1ns/100ps
interface decode_if;
	logic [7:0]                 opByte0;
	logic [7:0]                 opByte1;
	logic [7:0]                 modRm;
	logic                       protMode;
	logic                       flagCarry;
	logic                       flagZero;
	logic                       flagSign;
	logic                       flagOverflow;
	logic                       flagParity;
	setcc_sysreg_pkg::op_kind_t opKind;
	logic [2:0]                 cycles;
	logic                       illegal;
	logic                       condTrue;

	modport requester (output opByte0, opByte1, modRm, protMode, flagCarry, flagZero,
		flagSign, flagOverflow, flagParity, input opKind, cycles, illegal, condTrue);
	modport classifier (input opByte0, opByte1, modRm, protMode,
		output opKind, cycles, illegal);
	modport evaluator (input opByte1, flagCarry, flagZero, flagSign, flagOverflow,
		flagParity, output condTrue);
endinterface

// >>> op_classifier.sv
// Opcode classifier: instruction kind, clock count and illegal forms
`timescale 1ns/100ps
module op_classifier (
	decode_if.classifier bus
);
	logic [1:0] modField;
	logic [2:0] regField;

	always_comb begin
		modField    = bus.modRm[7:6];
		regField    = bus.modRm[5:3];
		bus.opKind  = setcc_sysreg_pkg::OP_NONE;
		bus.cycles  = setcc_sysreg_pkg::CYC_FAULT;
		bus.illegal = 1'b1;
		if (bus.opByte0 == setcc_sysreg_pkg::OPC_ESCAPE) begin
			if (bus.opByte1[7:4] == setcc_sysreg_pkg::OPC_SETCC_ROW) begin
				bus.opKind = setcc_sysreg_pkg::SET_ON_CONDITION;
				if (regField == setcc_sysreg_pkg::REG_SETCC) begin
					bus.cycles  = setcc_sysreg_pkg::CYC_SETCC; // see RL11
					bus.illegal = 1'b0;
				end
			end else if (bus.opByte1 == setcc_sysreg_pkg::OPC_GROUP_TABLE_MSW) begin
				if (regField == setcc_sysreg_pkg::REG_GLOBAL_TABLE
						&& modField != setcc_sysreg_pkg::MOD_REGISTER) begin
					bus.opKind  = setcc_sysreg_pkg::STORE_GLOBAL_TABLE_REG; // see RL12
					bus.cycles  = setcc_sysreg_pkg::CYC_TABLE;
					bus.illegal = 1'b0;
				end else if (regField == setcc_sysreg_pkg::REG_INTERRUPT_TABLE
						&& modField != setcc_sysreg_pkg::MOD_REGISTER) begin
					bus.opKind  = setcc_sysreg_pkg::STORE_INTERRUPT_TABLE_REG; // see RL13
					bus.cycles  = setcc_sysreg_pkg::CYC_TABLE;
					bus.illegal = 1'b0;
				end else if (regField == setcc_sysreg_pkg::REG_STATUS_WORD) begin
					bus.opKind  = setcc_sysreg_pkg::STORE_MACHINE_STATUS_WORD; // see RL16
					bus.cycles  = setcc_sysreg_pkg::CYC_STATUS;
					bus.illegal = 1'b0;
				end
			end else if (bus.opByte1 == setcc_sysreg_pkg::OPC_GROUP_LOCAL_TASK) begin
				if (regField == setcc_sysreg_pkg::REG_LOCAL_TABLE) begin
					bus.opKind = setcc_sysreg_pkg::STORE_LOCAL_TABLE_REG;
					if (bus.protMode) begin
						bus.cycles  = setcc_sysreg_pkg::CYC_LOCAL_PROT; // see RL14
						bus.illegal = 1'b0;
					end
				end else if (regField == setcc_sysreg_pkg::REG_TASK) begin
					bus.opKind  = setcc_sysreg_pkg::STORE_TASK_REG; // see RL15
					bus.cycles  = bus.protMode ? setcc_sysreg_pkg::CYC_TASK_PROT
						: setcc_sysreg_pkg::CYC_TASK_REAL;
					bus.illegal = 1'b0;
				end
			end
		end
	end
endmodule // op_classifier

// >>> setcc_condition.sv
// Condition evaluator for the set-byte-on-condition row
`timescale 1ns/100ps
module setcc_condition (
	decode_if.evaluator bus
);
	logic signedLess;
	logic baseCond;

	always_comb begin
		signedLess = bus.flagSign ^ bus.flagOverflow; // see RL18
		unique case (bus.opByte1[3:1])
			3'h0:    baseCond = bus.flagOverflow; // see RL8
			3'h1:    baseCond = bus.flagCarry; // see RL3, RL18
			3'h2:    baseCond = bus.flagZero; // see RL5
			3'h3:    baseCond = bus.flagCarry | bus.flagZero; // see RL4, RL18
			3'h4:    baseCond = bus.flagSign; // see RL10
			3'h5:    baseCond = bus.flagParity; // see RL9
			3'h6:    baseCond = signedLess; // see RL1, RL6
			3'h7:    baseCond = signedLess | bus.flagZero; // see RL2, RL7, RL18
		endcase
		// Odd opcodes are the negated form of the even one below them
		bus.condTrue = baseCond ^ bus.opByte1[0]; // see RL17
	end
endmodule // setcc_condition

// >>> fetch_mem_model.sv
// Far-side model: instruction fetch stage and data memory sink
`timescale 1ns/100ps
module fetch_mem_model (
	input  wire logic        sys_clk,
	input  wire logic        instReady,
	input  wire logic        memWrite,
	input  wire logic [47:0] wrData,
	output logic             instValid,
	output logic [7:0]       opByte0,
	output logic [7:0]       opByte1,
	output logic [7:0]       modRm,
	output logic             protMode,
	output logic [47:0]      memData,
	output int               memCount
);
	initial begin
		instValid = 1'b0;
		opByte0 = 8'h00;
		opByte1 = 8'h00;
		modRm = 8'h00;
		protMode = 1'b0;
		memData = 48'h0;
		memCount = 0;
	end

	// Holds the offer until accepted or 20 clocks pass, then scrambles the released fields
	task automatic offer(input logic [7:0] op, input logic [7:0] mrm, input logic prot,
			output bit ok);
		int n;
		@(posedge sys_clk);
		instValid <= 1'b1;
		opByte0 <= 8'h0F;
		opByte1 <= op;
		modRm <= mrm;
		protMode <= prot;
		ok = 1'b0;
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge sys_clk);
			ok = instReady;
		end
		instValid <= 1'b0;
		opByte0 <= 8'hF0;
		opByte1 <= ~op;
		modRm <= ~mrm;
		protMode <= ~prot;
	endtask

	always @(posedge sys_clk) begin
		if (memWrite) begin
			memData <= wrData;
			memCount <= memCount + 1;
		end
	end
endmodule // fetch_mem_model

// >>> setcc_and_store_sysreg_decode_tb_top.sv
// Self-checking bench for the set-on-condition and store-system-register slice
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checksDone++; if ((got) !== (exp)) begin errTotal++; \
	$display("[FAIL] %s exp %0h got %0h", nm, exp, got); end end
module setcc_and_store_sysreg_decode_tb_top;
	logic        sysClk, resetN, instValid, instReady, protMode;
	logic        retire, regWrite, memWrite, badOpcode;
	logic [7:0]  opByte0, opByte1, modRm;
	logic [4:0]  flg;
	logic [2:0]  destReg, wrBytes;
	logic [47:0] wrData, memData;
	logic [31:0] gdtB = 32'h8C412E07;
	logic [31:0] idtB = 32'h31D05A96;
	logic [15:0] gdtL = 16'h03F7, idtL = 16'h07A1, ldtS = 16'h2B48;
	logic [15:0] tskS = 16'h0D35, msw = 16'hC0E9;
	logic [4:0]  pat [4] = '{5'h00, 5'h1F, 5'h15, 5'h0A};
	int          memCount, errTotal, checksDone;

	setcc_sysreg_exec u_dut (.sys_clk(sysClk), .reset_n(resetN), .instValid(instValid),
		.instReady(instReady), .opByte0(opByte0), .opByte1(opByte1), .modRm(modRm),
		.protMode(protMode), .flagCarry(flg[4]), .flagZero(flg[3]), .flagSign(flg[2]),
		.flagOverflow(flg[1]), .flagParity(flg[0]), .gdtBase(gdtB), .gdtLimit(gdtL),
		.idtBase(idtB), .idtLimit(idtL), .ldtSelector(ldtS), .taskSelector(tskS),
		.statusWord(msw), .retire(retire), .regWrite(regWrite), .memWrite(memWrite),
		.badOpcode(badOpcode), .destReg(destReg), .wrBytes(wrBytes), .wrData(wrData));

	fetch_mem_model u_far (.sys_clk(sysClk), .instReady(instReady), .memWrite(memWrite),
		.wrData(wrData), .instValid(instValid), .opByte0(opByte0), .opByte1(opByte1),
		.modRm(modRm), .protMode(protMode), .memData(memData), .memCount(memCount));

	initial begin
		sysClk = 1'b0;
		forever #5 sysClk = ~sysClk;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Flags are {carry, zero, sign, overflow, parity}; odd codes negate
	function automatic logic cond(input logic [3:0] lo, input logic [4:0] f);
		logic r;
		case (lo[3:1])
			3'h0: r = f[1];
			3'h1: r = f[4];
			3'h2: r = f[3];
			3'h3: r = f[4] | f[3];
			3'h4: r = f[2];
			3'h5: r = f[0];
			3'h6: r = f[2] ^ f[1];
			default: r = (f[2] ^ f[1]) | f[3];
		endcase
		return r ^ lo[0];
	endfunction

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Kind: 0 register write, 1 memory write, 2 refused
	task automatic run(input logic [7:0] op, input logic [7:0] mrm, input logic prot,
			input int n, input logic [47:0] dat, input logic [2:0] nb, input int kind);
		bit ok;
		int k;
		int mc;
		mc = memCount;
		u_far.offer(op, mrm, prot, ok);
		if (!ok) begin
			errTotal++;
			$display("[FAIL] accept exp 1 got 0");
			end_sim();
		end
		k = 1;
		#1;
		while (retire !== 1'b1 && k < 10) begin
			if (n > 1) `CHK("busy ready", 1'b0, instReady)
			@(posedge sysClk);
			#1;
			k++;
		end
		if (retire !== 1'b1) begin
			errTotal++;
			$display("[FAIL] retire exp 1 got 0");
			end_sim();
		end
		`CHK("latency", n, k)
		`CHK("regWrite", kind == 0, regWrite)
		`CHK("memWrite", kind == 1, memWrite)
		`CHK("badOpcode", kind == 2, badOpcode)
		`CHK("destReg", mrm[2:0], destReg)
		`CHK("ready", 1'b1, instReady)
		if (kind != 2) begin
			`CHK("wrBytes", nb, wrBytes)
			`CHK("wrData", dat, wrData)
		end
		@(posedge sysClk);
		#1;
		`CHK("retire pulse", 1'b0, retire)
		`CHK("memCount", mc + (kind == 1), memCount)
		if (kind == 1) `CHK("memData", dat, memData)
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_setcc();
		int i;
		int j;
		for (i = 0; i < 16; i++) begin
			for (j = 0; j < 4; j++) begin
				@(posedge sysClk);
				flg <= pat[j];
				run(8'h90 | 8'(i), {j[0] ? 2'h3 : 2'h0, 3'h0, 3'(i)}, j[1], 1,
					{47'h0, cond(4'(i), pat[j])}, 3'h1, j[0] ? 0 : 1);
			end
		end
		$display("test setcc done");
	endtask

	task automatic t_refuse();
		run(8'h9C, 8'hD1, 1'b1, 1, 48'h0, 3'h0, 2);
		run(8'h01, 8'hC2, 1'b1, 1, 48'h0, 3'h0, 2);
		run(8'h01, 8'h15, 1'b1, 1, 48'h0, 3'h0, 2);
		run(8'h00, 8'hC4, 1'b0, 1, 48'h0, 3'h0, 2);
		$display("test refuse done");
	endtask

	task automatic t_sysreg();
		int i;
		for (i = 0; i < 2; i++) begin
			run(8'h01, 8'h05, i[0], 6, {gdtB, gdtL}, 3'h6, 1);
			run(8'h01, 8'h4D, i[0], 6, {idtB, idtL}, 3'h6, 1);
			run(8'h01, 8'hE7, i[0], 4, {32'h0, msw}, 3'h2, 0);
		end
		run(8'h00, 8'hC3, 1'b1, 1, {32'h0, ldtS}, 3'h2, 0);
		run(8'h00, 8'h0E, 1'b0, 4, {32'h0, tskS}, 3'h2, 1);
		run(8'h00, 8'hCD, 1'b1, 3, {32'h0, tskS}, 3'h2, 0);
		$display("test sysreg done");
	endtask

	initial begin
		errTotal = 0;
		checksDone = 0;
		flg = 5'h00;
		resetN = 1'b0;
		repeat (10) @(posedge sysClk);
		resetN <= 1'b1;
		repeat (3) @(posedge sysClk);
		#1;
		`CHK("reset ready", 1'b1, instReady)
		`CHK("reset retire", 1'b0, retire)
		t_setcc();
		t_refuse();
		t_sysreg();
		end_sim();
	end
endmodule // setcc_and_store_sysreg_decode_tb_top
